// ==== shared/cal_regs_pkg.sv ====
// Purpose: constants and carriers for the channel calibration register bank
// Assumes: word-addressed registers, index times four gives the byte address
// Notes:   none
package cal_regs_pkg;
   // ----------------------------------------
   // register indices
   // ----------------------------------------
   localparam logic [7:0] IDX_OFFSET_UPPER = 8'h19;
   localparam logic [7:0] IDX_OFFSET_LOWER = 8'h1A;
   localparam logic [7:0] IDX_GAIN_UPPER   = 8'h1B;
   localparam logic [7:0] IDX_GAIN_LOWER   = 8'h1C;
   localparam int         ADDR_W           = 10;
   // ----------------------------------------
   // field layout and reset values
   // ----------------------------------------
   localparam int          LOW_FIELD_MSB   = 15;
   localparam int          LOW_FIELD_LSB   = 8;
   localparam logic [15:0] LOW_FIELD_MASK  = 16'hFF00;
   localparam logic [15:0] RST_OFFSET_UPPER = 16'h0000;
   localparam logic [15:0] RST_OFFSET_LOWER = 16'h0000;
   localparam logic [15:0] RST_GAIN_UPPER   = 16'h8000;
   localparam logic [15:0] RST_GAIN_LOWER   = 16'h0000;
   localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

   typedef struct packed {
      logic signed [23:0] offset_corr;
      logic        [23:0] gain_corr;
   } cal_values_s;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [ADDR_W-1:0] address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avmm_req_s;
endpackage : cal_regs_pkg

// ==== core/channel_offset_gain_calibration_regs.sv ====
// Purpose: calibration register bank for one channel (offset and gain constants)
// Assumes: Avalon-MM slave, 32-bit data, one access accepted per two cycles
// Notes:   constants leave on cal_out; arithmetic on them lives elsewhere
//
// Functional notes
// RULE1: offset upper register at 19h holds offset bits 23:8, reset zero.
// RULE2: offset lower register at 1Ah bits 15:8 hold offset bits 7:0, read/write.
// RULE3: assembled 24-bit offset is a signed two's complement value.
// RULE4: gain upper register at 1Bh resets to 8000h, unity gain.
// RULE5: gain upper register holds gain bits 23:8 in all sixteen bits.
// RULE6: gain lower register at 1Ch bits 15:8 hold gain bits 7:0, reset zero.
// RULE7: gain is unsigned fraction 0.0 to below 2.0, lsb is 2^-23.
// RULE8: offset upper register resets to 0000h.
// RULE9: lower registers bits 7:0 read zero and ignore writes.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
module channel_offset_gain_calibration_regs #(
   parameter int ADDR_W = cal_regs_pkg::ADDR_W
) (
   // clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic                     clk_en,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]        avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [3:0]               avs_byteenable,
   input  wire logic [31:0]              avs_writedata,
   output logic      [31:0]              avs_readdata,
   output logic                          avs_waitrequest,
   // calibration constants
   output cal_regs_pkg::cal_values_s     cal_out
);
   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   if (ADDR_W < 7) begin : g_bad_addr
      $error("address width too small for register indices");
   end
   if (ADDR_W != cal_regs_pkg::ADDR_W) begin : g_bad_carrier
      $error("address width must match the request carrier");
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // merge write data into a 16-bit register under byte enables and a mask
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be,
                                           input logic [15:0] keep_mask);
      logic [15:0] lane_m;
      lane_m = {{8{be[1]}}, {8{be[0]}}} & keep_mask;
      return (old_v & ~lane_m) | (wd & lane_m);
   endfunction : merge16

   function automatic logic is_idx(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      logic [ADDR_W-1:0] want;
      want = ADDR_W'({idx, 2'b00});
      return a == want;
   endfunction : is_idx

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   cal_regs_pkg::avmm_req_s req;
   logic [15:0] off_up_r;
   logic [15:0] off_lo_r;
   logic [15:0] gain_up_r;
   logic [15:0] gain_lo_r;
   logic [31:0] rdata_r;
   logic        ack_r;
   logic [15:0] off_up_nxt;
   logic [15:0] off_lo_nxt;
   logic [15:0] gain_up_nxt;
   logic [15:0] gain_lo_nxt;
   logic [31:0] rdata_nxt;

   assign req = '{read: avs_read, write: avs_write, address: avs_address,
                  byteenable: avs_byteenable, writedata: avs_writedata};

   // access completes on the cycle ack_r is high; waitrequest drops then
   wire take      = clk_en && !ack_r && (req.read || req.write);
   wire wr_go     = take && req.write;
   wire hit_ou    = is_idx(req.address, cal_regs_pkg::IDX_OFFSET_UPPER);
   wire hit_ol    = is_idx(req.address, cal_regs_pkg::IDX_OFFSET_LOWER);
   wire hit_gu    = is_idx(req.address, cal_regs_pkg::IDX_GAIN_UPPER);
   wire hit_gl    = is_idx(req.address, cal_regs_pkg::IDX_GAIN_LOWER);
   wire [15:0] wd16 = req.writedata[15:0];
   wire [1:0]  be16 = req.byteenable[1:0];

   assign off_up_nxt  = (wr_go && hit_ou) ? merge16(off_up_r, wd16, be16, 16'hFFFF) : off_up_r; // RULE1
   assign off_lo_nxt  = (wr_go && hit_ol) ?
                        merge16(off_lo_r, wd16, be16, cal_regs_pkg::LOW_FIELD_MASK) : off_lo_r; // RULE2 RULE9
   assign gain_up_nxt = (wr_go && hit_gu) ? merge16(gain_up_r, wd16, be16, 16'hFFFF) : gain_up_r; // RULE5
   assign gain_lo_nxt = (wr_go && hit_gl) ?
                        merge16(gain_lo_r, wd16, be16, cal_regs_pkg::LOW_FIELD_MASK) : gain_lo_r; // RULE6 RULE9

   // unmapped addresses read zero and swallow writes
   wire [15:0] rsel = hit_ou ? off_up_r  :
                      hit_ol ? (off_lo_r & cal_regs_pkg::LOW_FIELD_MASK) : // RULE9
                      hit_gu ? gain_up_r :
                      hit_gl ? (gain_lo_r & cal_regs_pkg::LOW_FIELD_MASK) : 16'h0000;
   wire mapped = hit_ou || hit_ol || hit_gu || hit_gl;
   assign rdata_nxt = (take && req.read) ?
                      (mapped ? {16'h0000, rsel} : cal_regs_pkg::UNMAPPED_READ) : rdata_r;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         off_up_r  <= cal_regs_pkg::RST_OFFSET_UPPER; // RULE8
         off_lo_r  <= cal_regs_pkg::RST_OFFSET_LOWER;
         gain_up_r <= cal_regs_pkg::RST_GAIN_UPPER; // RULE4
         gain_lo_r <= cal_regs_pkg::RST_GAIN_LOWER; // RULE6
      end else if (clk_en) begin
         off_up_r  <= off_up_nxt;
         off_lo_r  <= off_lo_nxt;
         gain_up_r <= gain_up_nxt;
         gain_lo_r <= gain_lo_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (clk_en) begin
         ack_r   <= take;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // registered waitrequest: high except in the answering cycle
   logic wait_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_r <= 1'b1;
      end else if (clk_en) begin
         wait_r <= !take;
      end
   end
   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   // signed offset, unsigned gain q1.23; both wired straight from registers
   localparam int LF_HI = cal_regs_pkg::LOW_FIELD_MSB;
   localparam int LF_LO = cal_regs_pkg::LOW_FIELD_LSB;
   wire [23:0] off_word  = {off_up_r, off_lo_r[LF_HI:LF_LO]}; // RULE1 RULE2
   wire [23:0] gain_word = {gain_up_r, gain_lo_r[LF_HI:LF_LO]}; // RULE5 RULE6
   assign cal_out = '{offset_corr: $signed(off_word), gain_corr: gain_word}; // RULE3 RULE7

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_off_up_reset;
      @(posedge clk) sys_rst |=> (off_up_r == 16'h0000);
   endproperty
   a_off_up_reset: assert property (p_off_up_reset) else $error("offset upper not cleared by reset"); // RULE8

   property p_gain_reset;
      @(posedge clk) sys_rst |=> (cal_out.gain_corr == 24'h800000);
   endproperty
   a_gain_reset: assert property (p_gain_reset) else $error("gain not unity after reset"); // RULE4

   property p_off_up_write;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_ou && be16 == 2'b11) |=> (cal_out.offset_corr[23:8] == $past(wd16));
   endproperty
   a_off_up_write: assert property (p_off_up_write) else $error("offset upper write lost"); // RULE1

   property p_off_lo_write;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_ol && be16[1]) |=> (cal_out.offset_corr[7:0] == $past(wd16[15:8]));
   endproperty
   a_off_lo_write: assert property (p_off_lo_write) else $error("offset low bits write lost"); // RULE2

   property p_gain_up_write;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_gu && be16 == 2'b11) |=> (cal_out.gain_corr[23:8] == $past(wd16));
   endproperty
   a_gain_up_write: assert property (p_gain_up_write) else $error("gain upper write lost"); // RULE5

   property p_gain_lo_write;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_gl && be16[1]) |=> (cal_out.gain_corr[7:0] == $past(wd16[15:8]));
   endproperty
   a_gain_lo_write: assert property (p_gain_lo_write) else $error("gain low bits write lost"); // RULE6

   property p_low_reserved;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && (hit_ol || hit_gl)) |=> (avs_readdata[7:0] == 8'h00) && !avs_waitrequest;
   endproperty
   a_low_reserved: assert property (p_low_reserved) else $error("reserved low bits read nonzero"); // RULE9

   property p_offset_sign;
      @(posedge clk) disable iff (sys_rst)
         (cal_out.offset_corr < 0) == off_up_r[15];
   endproperty
   a_offset_sign: assert property (p_offset_sign) else $error("offset sign not from top bit"); // RULE3

   property p_gain_stable;
      @(posedge clk) disable iff (sys_rst)
         !(wr_go && (hit_gu || hit_gl)) |=> $stable(cal_out.gain_corr);
   endproperty
   a_gain_stable: assert property (p_gain_stable) else $error("gain changed without a write"); // RULE7

   property p_answer_bound;
      @(posedge clk) disable iff (sys_rst)
         ((avs_read || avs_write) && clk_en && avs_waitrequest) |-> ##[1:2] !avs_waitrequest;
   endproperty
   a_answer_bound: assert property (p_answer_bound) else $error("access not answered in time");

   property p_off_lo_reset;
      @(posedge clk) sys_rst |=> (off_lo_r == 16'h0000);
   endproperty
   a_off_lo_reset: assert property (p_off_lo_reset) else $error("offset lower not cleared by reset"); // RULE2

   property p_gain_up_rst;
      @(posedge clk) sys_rst |=> (gain_up_r == 16'h8000);
   endproperty
   a_gain_up_rst: assert property (p_gain_up_rst) else $error("gain upper not unity after reset"); // RULE4

   property p_gain_lo_reset;
      @(posedge clk) sys_rst |=> (gain_lo_r == 16'h0000);
   endproperty
   a_gain_lo_reset: assert property (p_gain_lo_reset) else $error("gain lower not cleared by reset"); // RULE6

   property p_offset_reset;
      @(posedge clk) sys_rst |=> (cal_out.offset_corr == 24'h000000);
   endproperty
   a_offset_reset: assert property (p_offset_reset) else $error("offset not zero after reset"); // RULE8

   property p_bus_reset;
      @(posedge clk) sys_rst |=> (avs_waitrequest && (avs_readdata == 32'h0000_0000));
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus outputs not idle after reset");

   property p_off_lo_spare;
      @(posedge clk) disable iff (sys_rst)
         (off_lo_r[7:0] == 8'h00);
   endproperty
   a_off_lo_spare: assert property (p_off_lo_spare) else $error("offset lower spare bits not zero"); // RULE9

   property p_gain_lo_spare;
      @(posedge clk) disable iff (sys_rst)
         (gain_lo_r[7:0] == 8'h00);
   endproperty
   a_gain_lo_spare: assert property (p_gain_lo_spare) else $error("gain lower spare bits not zero"); // RULE9

   property p_off_stable;
      @(posedge clk) disable iff (sys_rst)
         !(wr_go && (hit_ou || hit_ol)) |=> $stable(cal_out.offset_corr);
   endproperty
   a_off_stable: assert property (p_off_stable) else $error("offset changed without a write"); // RULE1

   property p_off_up_low_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_ou && be16 == 2'b01) |=> (off_up_r == {$past(off_up_r[15:8]), $past(wd16[7:0])});
   endproperty
   a_off_up_low_lane: assert property (p_off_up_low_lane) else $error("offset upper low lane wrong"); // RULE1

   property p_off_up_high_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_ou && be16 == 2'b10) |=> (off_up_r == {$past(wd16[15:8]), $past(off_up_r[7:0])});
   endproperty
   a_off_up_high_lane: assert property (p_off_up_high_lane) else $error("offset upper high lane wrong"); // RULE1

   property p_gain_up_low_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_gu && be16 == 2'b01) |=> (gain_up_r == {$past(gain_up_r[15:8]), $past(wd16[7:0])});
   endproperty
   a_gain_up_low_lane: assert property (p_gain_up_low_lane) else $error("gain upper low lane wrong"); // RULE5

   property p_gain_up_high_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_gu && be16 == 2'b10) |=> (gain_up_r == {$past(wd16[15:8]), $past(gain_up_r[7:0])});
   endproperty
   a_gain_up_high_lane: assert property (p_gain_up_high_lane) else $error("gain upper high lane wrong"); // RULE5

   property p_off_lo_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_ol && !be16[1]) |=> $stable(off_lo_r);
   endproperty
   a_off_lo_lane: assert property (p_off_lo_lane) else $error("offset lower changed by low lane"); // RULE2

   property p_gain_lo_lane;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && hit_gl && !be16[1]) |=> $stable(gain_lo_r);
   endproperty
   a_gain_lo_lane: assert property (p_gain_lo_lane) else $error("gain lower changed by low lane"); // RULE6

   property p_rd_off_up;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && hit_ou) |=> (avs_readdata == {16'h0000, $past(off_up_r)});
   endproperty
   a_rd_off_up: assert property (p_rd_off_up) else $error("offset upper read wrong"); // RULE1

   property p_rd_off_lo;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && hit_ol) |=> (avs_readdata[15:8] == $past(off_lo_r[15:8]));
   endproperty
   a_rd_off_lo: assert property (p_rd_off_lo) else $error("offset lower read wrong"); // RULE2

   property p_rd_gain_up;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && hit_gu) |=> (avs_readdata == {16'h0000, $past(gain_up_r)});
   endproperty
   a_rd_gain_up: assert property (p_rd_gain_up) else $error("gain upper read wrong"); // RULE5

   property p_rd_gain_lo;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && hit_gl) |=> (avs_readdata[15:8] == $past(gain_lo_r[15:8]));
   endproperty
   a_rd_gain_lo: assert property (p_rd_gain_lo) else $error("gain lower read wrong"); // RULE6

   property p_rd_unmapped;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read && !mapped) |=> (avs_readdata == 32'h0000_0000);
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

   property p_rd_upper_zero;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read) |=> (avs_readdata[31:16] == 16'h0000);
   endproperty
   a_rd_upper_zero: assert property (p_rd_upper_zero) else $error("read data upper half not zero");

   property p_wr_unmapped;
      @(posedge clk) disable iff (sys_rst)
         (wr_go && !mapped) |=> $stable(cal_out);
   endproperty
   a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write changed a register");

   property p_freeze;
      @(posedge clk) disable iff (sys_rst)
         !clk_en |=> ($stable(cal_out) && $stable(avs_readdata) && $stable(avs_waitrequest));
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while enable low");

   property p_wait_one;
      @(posedge clk) disable iff (sys_rst)
         (!avs_waitrequest && clk_en) |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer cycle longer than one");

   property p_read_quiet;
      @(posedge clk) disable iff (sys_rst)
         (take && req.read) |=> $stable(cal_out);
   endproperty
   a_read_quiet: assert property (p_read_quiet) else $error("read changed a register");

   property p_rd_hold;
      @(posedge clk) disable iff (sys_rst)
         !(take && req.read) |=> $stable(avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without a read");
endmodule : channel_offset_gain_calibration_regs

// ==== bench/testbench.sv ====
// Purpose: self-checking bench for the channel calibration register bank
// Assumes: one wait cycle per access, byte address is register index times four
// Notes:   a shadow copy of the four registers predicts reads and cal_out
`timescale 1ns/100ps
module testbench;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic                      clk            = 1'b0;
   logic                      sys_rst        = 1'b1;
   logic                      clk_en         = 1'b1;
   logic [9:0]                avs_address    = 10'h000;
   logic                      avs_read       = 1'b0;
   logic                      avs_write      = 1'b0;
   logic [3:0]                avs_byteenable = 4'h0;
   logic [31:0]               avs_writedata  = 32'h0;
   logic [31:0]               avs_readdata;
   logic                      avs_waitrequest;
   cal_regs_pkg::cal_values_s cal_out;
   logic [15:0]               shadow [4];
   logic [31:0]               rd;
   int                        fails = 0;
   int                        num_checks = 0;

   channel_offset_gain_calibration_regs dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cal_out(cal_out));

   always #12.5 clk = ~clk;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task close_out;
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   task check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one idle edge first, so strobes never change twice in one step
   task bus(input logic wr, input logic [7:0] idx, input logic [3:0] be, input logic [31:0] d);
      @(posedge clk);
      avs_address    <= {idx, 2'b00};
      avs_read       <= !wr;
      avs_write      <= wr;
      avs_byteenable <= be;
      avs_writedata  <= d;
      // no limit here: only the watchdog ends a wait
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task model_wr(input logic [7:0] idx, input logic [3:0] be, input logic [31:0] d);
      int k;
      k = idx - 8'h19;
      if (idx >= 8'h19 && idx <= 8'h1C) begin
         if (be[0] && k % 2 == 0) shadow[k][7:0] = d[7:0];
         if (be[1]) shadow[k][15:8] = d[15:8];
      end
   endtask : model_wr

   function automatic logic [31:0] exp_rd(input logic [7:0] idx);
      if (idx < 8'h19 || idx > 8'h1C) return 32'h0000_0000;
      return {16'h0000, shadow[idx - 8'h19]};
   endfunction : exp_rd

   task do_reset;
      sys_rst <= 1'b1;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      shadow = '{16'h0000, 16'h0000, 16'h8000, 16'h0000};
      bus(1'b0, 8'h19, 4'hF, 32'h0); check("offset_upper_rst", rd, 32'h0000_0000);
      bus(1'b0, 8'h1A, 4'hF, 32'h0); check("offset_lower_rst", rd, 32'h0000_0000);
      bus(1'b0, 8'h1B, 4'hF, 32'h0); check("gain_upper_rst", rd, 32'h0000_8000);
      bus(1'b0, 8'h1C, 4'hF, 32'h0); check("gain_lower_rst", rd, 32'h0000_0000);
      check("cal_out_rst", cal_out, 48'h000000_800000);
   endtask : do_reset

   task wr_rd(input logic [7:0] idx, input logic [3:0] be, input logic [31:0] d);
      bus(1'b1, idx, be, d);
      model_wr(idx, be, d);
      check("offset", $unsigned(cal_out.offset_corr), {shadow[0], shadow[1][15:8]});
      check("gain", cal_out.gain_corr, {shadow[2], shadow[3][15:8]});
      check("offset_sign", $signed(cal_out.offset_corr) < 0, shadow[0][15]);
      bus(1'b0, idx, 4'hF, 32'h0);
      check("readback", rd, exp_rd(idx));
   endtask : wr_rd
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      close_out;
   end

   initial begin
      void'($urandom(65551));
      do_reset;
      // corners: all ones, unmapped neighbours, partial lanes
      for (int i = 8'h18; i <= 8'h1D; i++) wr_rd(i[7:0], 4'h3, 32'hFFFF_FFFF);
      wr_rd(8'h1A, 4'h1, 32'h0000_0000);
      wr_rd(8'h19, 4'h2, 32'h0000_0000);
      for (int i = 0; i < 80; i++) wr_rd(8'h18 + 8'($urandom % 6), 4'($urandom), $urandom);
      // frozen enable: neither a read nor a write may be answered or land
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         clk_en         <= 1'b0;
         avs_read       <= (m == 0);
         avs_write      <= (m == 1);
         avs_address    <= {8'h19, 2'b00};
         avs_byteenable <= 4'hF;
         avs_writedata  <= ~{16'h0000, shadow[0]};
         repeat (4) begin
            @(posedge clk);
            check("frozen_wait", avs_waitrequest, 1'b1);
            check("frozen_offset", $unsigned(cal_out.offset_corr), {shadow[0], shadow[1][15:8]});
         end
         clk_en    <= 1'b1;
         avs_read  <= 1'b0;
         avs_write <= 1'b0;
      end
      wr_rd(8'h1C, 4'h3, 32'h0000_A5C3);
      // second reset mid-run must restore defaults
      do_reset;
      close_out;
   end
endmodule : testbench
